// [rrcc_pkg.sv]
// Package holding register map, field positions and types for the ROM region cache control.
package rrcc_pkg;
  // Register byte addresses: printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is four times it.
  localparam logic [7:0] IDX_SHADOW_WP   = 8'h32;
  localparam logic [7:0] IDX_DRAM_CTL2   = 8'h35;
  localparam logic [7:0] IDX_SHADOW_CTL3 = 8'h36;
  localparam logic [7:0] IDX_E_CACHE     = 8'h37;
  localparam logic [7:0] IDX_NCB2_CTL    = 8'h3a;
  localparam logic [7:0] IDX_NCB2_START  = 8'h3b;
  localparam logic [7:0] IDX_MISC_CTL    = 8'h3f;
  localparam logic [7:0] IDX_FEAT_CTL1   = 8'ha0;
  localparam logic [7:0] IDX_FEAT_CTL2   = 8'ha1;
  localparam logic [7:0] IDX_L2_CTL      = 8'hd0;
  localparam logic [7:0] IDX_L2_E_EN     = 8'hd1;
  localparam logic [7:0] IDX_L2_CD_EN    = 8'hd2;
  localparam logic [7:0] IDX_SHADOW_EN   = 8'hd3;
  localparam logic [7:0] IDX_STATUS      = 8'hd8;

  // Reset values.
  localparam logic [7:0] RST_DRAM_CTL2 = 8'hff;
  localparam logic [7:0] RST_E_CACHE   = 8'h0f;
  localparam logic [7:0] RST_NCB2_CTL  = 8'h80;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  // Field positions.
  localparam int B_C_EN       = 0;
  localparam int B_GLOBAL_DIS = 1;
  localparam int B_F_EN       = 2;
  localparam int B_C_WP       = 5;
  localparam int B_E_WP       = 3;
  localparam int B_D_WP       = 4;
  localparam int B_NEW_MAP    = 0;
  localparam int B_F_RW       = 1;
  localparam int B_INVAL_EN   = 2;
  localparam int B_L2_EN      = 5;
  localparam int B_NCB_HI     = 0;

  // Size code of the second non-cacheable block that selects 256KB.
  localparam logic [2:0] NCB_SZ_256K = 3'b010;

  // Address fields within the 24-bit processor address.
  localparam logic [3:0] SEG_C = 4'hc;
  localparam logic [3:0] SEG_D = 4'hd;
  localparam logic [3:0] SEG_E = 4'he;
  localparam logic [3:0] SEG_F = 4'hf;
  localparam logic [3:0] TOP_1M = 4'h0;

  typedef struct packed {
    logic [23:0] addr;
    logic        write;
    logic        start;
  } rrcc_cyc_t;

  typedef struct packed {
    logic l1_cacheable;
    logic l2_cacheable;
    logic block_write;
    logic snoop_inval;
    logic valid;
  } rrcc_dec_t;
endpackage : rrcc_pkg

// [rrcc_top.sv]
// ROM region cacheability decision logic with its APB register file.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Nothing in C0000h-FFFFFh is cacheable unless global caching bit is 0.
// - A ROM region is non-cacheable at both levels unless shadowed in DRAM.
// - Mapping mode bit resets to 0 (compatible); 1 adds writability interlock.
// - Compatible mode: C0000h 32KB block L1-cacheable when its enable is 0.
// - C8000h 32KB and D0000h 64KB blocks are never L1-cacheable.
// - Compatible mode: each E-segment 16KB block L1-cacheable when its bit is 0.
// - Compatible mode: F0000h block L1-cacheable when F enable bit is 0.
// - New mode: C0000h L1-cacheable needs enable 0 and C write-protect 0.
// - New mode: E blocks L1-cacheable need enable 0 and E write-protect 0.
// - New mode: F0000h L1-cacheable needs enable 0 and F read-write bit 1.
// - L2 decisions ignore the mapping mode bit.
// - C 16KB blocks L2-cacheable when enabled; writes only if C writable.
// - D 16KB blocks L2-cacheable when enabled; writes only if D writable.
// - E 16KB blocks L2-cacheable when enabled; writes only if E writable.
// - F block L2-cacheable when enable 0; writes only if read-write bit 1.
// - Writes to write-protected shadow block L2 and DRAM updates.
// - Clearing the L2 enable bit disables the external cache.
// - Base variant keeps write-protected DRAM out of the L1 cache.
// - Later variant: invalidate bit plus L1-cacheable shadow write pulses snoop.
// - Misc control resets to 00h; bit 2 enables invalidation on L1-cacheable shadow writes.
// - Block 2 size code 010 means 256KB; start from high bit and start byte.
module rrcc_top #(
  parameter bit LATER_VARIANT = 1'b1
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire rrcc_pkg::rrcc_cyc_t cyc,
  output var rrcc_pkg::rrcc_dec_t dec,
  output logic                   l2_enable,
  output logic                   eads_n
);
  // ==========================================================================
  // Register file
  logic [7:0] wp_q, dram2_q, shadow3_q, ecache_q, ncb_ctl_q, ncb_st_q;
  logic [7:0] misc_q, feat1_q, feat2_q, l2ctl_q, l2e_q, l2cd_q, shen_q;

  wire        acc     = psel & penable;
  wire        wr_acc  = acc & pwrite;
  wire [7:0]  idx     = paddr[9:2];
  wire        aligned = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
  wire        hit_wp  = aligned & (idx == rrcc_pkg::IDX_SHADOW_WP);
  wire        hit_d2  = aligned & (idx == rrcc_pkg::IDX_DRAM_CTL2);
  wire        hit_s3  = aligned & (idx == rrcc_pkg::IDX_SHADOW_CTL3);
  wire        hit_ec  = aligned & (idx == rrcc_pkg::IDX_E_CACHE);
  wire        hit_nc  = aligned & (idx == rrcc_pkg::IDX_NCB2_CTL);
  wire        hit_ns  = aligned & (idx == rrcc_pkg::IDX_NCB2_START);
  wire        hit_mi  = aligned & (idx == rrcc_pkg::IDX_MISC_CTL);
  wire        hit_f1  = aligned & (idx == rrcc_pkg::IDX_FEAT_CTL1);
  wire        hit_f2  = aligned & (idx == rrcc_pkg::IDX_FEAT_CTL2);
  wire        hit_l2  = aligned & (idx == rrcc_pkg::IDX_L2_CTL);
  wire        hit_le  = aligned & (idx == rrcc_pkg::IDX_L2_E_EN);
  wire        hit_lc  = aligned & (idx == rrcc_pkg::IDX_L2_CD_EN);
  wire        hit_sh  = aligned & (idx == rrcc_pkg::IDX_SHADOW_EN);
  wire        hit_st  = aligned & (idx == rrcc_pkg::IDX_STATUS);
  wire        mapped  = hit_wp | hit_d2 | hit_s3 | hit_ec | hit_nc | hit_ns |
                        hit_mi | hit_f1 | hit_f2 | hit_l2 | hit_le | hit_lc |
                        hit_sh | hit_st;
  wire [7:0]  wd      = pwdata[7:0];

  always_ff @(posedge clock) begin
    if (rst) begin
      wp_q      <= rrcc_pkg::RST_ZERO;
      dram2_q   <= rrcc_pkg::RST_DRAM_CTL2;
      shadow3_q <= rrcc_pkg::RST_ZERO;
      ecache_q  <= rrcc_pkg::RST_E_CACHE;
      ncb_ctl_q <= rrcc_pkg::RST_NCB2_CTL;
      ncb_st_q  <= rrcc_pkg::RST_ZERO;
      misc_q    <= rrcc_pkg::RST_ZERO;
      feat1_q   <= rrcc_pkg::RST_ZERO;
      feat2_q   <= rrcc_pkg::RST_ZERO;
      l2ctl_q   <= rrcc_pkg::RST_ZERO;
      l2e_q     <= rrcc_pkg::RST_ZERO;
      l2cd_q    <= rrcc_pkg::RST_ZERO;
      shen_q    <= rrcc_pkg::RST_ZERO;
    end else if (wr_acc) begin
      if (hit_wp) wp_q <= wd;
      if (hit_d2) dram2_q <= wd;
      if (hit_s3) shadow3_q <= wd;
      if (hit_ec) ecache_q <= wd;
      if (hit_nc) ncb_ctl_q <= wd;
      if (hit_ns) ncb_st_q <= wd;
      if (hit_mi) misc_q <= wd;
      if (hit_f1) feat1_q <= wd;
      if (hit_f2) feat2_q <= wd;
      if (hit_l2) l2ctl_q <= wd;
      if (hit_le) l2e_q <= wd;
      if (hit_lc) l2cd_q <= wd;
      if (hit_sh) shen_q <= wd;
    end
  end

  // ==========================================================================
  // Cacheability decode
  wire [3:0] seg    = cyc.addr[19:16];
  wire [1:0] q16    = cyc.addr[15:14];
  wire       in_1m  = cyc.addr[23:20] == rrcc_pkg::TOP_1M;
  wire       is_c   = in_1m & (seg == rrcc_pkg::SEG_C);
  wire       is_d   = in_1m & (seg == rrcc_pkg::SEG_D);
  wire       is_e   = in_1m & (seg == rrcc_pkg::SEG_E);
  wire       is_f   = in_1m & (seg == rrcc_pkg::SEG_F);
  wire       rom    = is_c | is_d | is_e | is_f;
  // One shadow-enable bit per segment, C/D/E/F in bits 0..3.
  wire [1:0] sidx   = seg[1:0];
  wire       shadow = shen_q[sidx];
  wire       glob   = ~dram2_q[rrcc_pkg::B_GLOBAL_DIS];
  wire       newmap = feat1_q[rrcc_pkg::B_NEW_MAP];
  wire       c_wp   = shadow3_q[rrcc_pkg::B_C_WP];
  wire       d_wp   = wp_q[rrcc_pkg::B_D_WP];
  wire       e_wp   = wp_q[rrcc_pkg::B_E_WP];
  wire       f_rw   = feat2_q[rrcc_pkg::B_F_RW];
  wire       c_en0  = ~dram2_q[rrcc_pkg::B_C_EN];
  wire       f_en0  = ~dram2_q[rrcc_pkg::B_F_EN];
  wire       e_en0  = ~ecache_q[q16];
  wire       c_lo   = ~cyc.addr[15];

  // The new mapping only admits blocks whose shadow copy is writable, so
  // the processor cache cannot diverge from protected DRAM.
  wire l1_c  = c_lo & c_en0 & (~newmap | ~c_wp);
  wire l1_e  = e_en0 & (~newmap | ~e_wp);
  wire l1_f  = f_en0 & (~newmap | f_rw);
  wire l1_sel = (is_c & l1_c) | (is_e & l1_e) | (is_f & l1_f);
  // Base variant never lets a protected block into L1 in either mode.
  wire prot  = (is_c & c_wp) | (is_d & d_wp) | (is_e & e_wp) | (is_f & ~f_rw);
  wire base_ok = LATER_VARIANT | ~prot;
  wire l1_ok = rom & shadow & glob & l1_sel & base_ok;

  wire [1:0] l2i   = q16;
  wire l2_c  = l2cd_q[{1'b0, l2i}] & (~cyc.write | ~c_wp);
  wire l2_d  = l2cd_q[{1'b1, l2i}] & (~cyc.write | ~d_wp);
  wire l2_e  = l2e_q[l2i] & (~cyc.write | ~e_wp);
  wire l2_f  = f_en0 & (~cyc.write | f_rw);
  wire l2_on = l2ctl_q[rrcc_pkg::B_L2_EN];
  wire l2_sel = (is_c & l2_c) | (is_d & l2_d) | (is_e & l2_e) | (is_f & l2_f);
  wire l2_ok = rom & shadow & glob & l2_on & l2_sel;

  wire blk_w = rom & shadow & cyc.write & prot;
  wire inval = LATER_VARIANT & misc_q[rrcc_pkg::B_INVAL_EN] &
               cyc.write & rom & shadow & glob & l1_sel;

  // Second non-cacheable block: size code 010 covers a 256KB window.
  wire ncb_on  = ncb_ctl_q[7:5] == rrcc_pkg::NCB_SZ_256K;
  wire [8:0] ncb_base = {ncb_ctl_q[rrcc_pkg::B_NCB_HI], ncb_st_q};
  wire ncb_hit = ncb_on & (cyc.addr[23:18] == ncb_base[7:2]) &
                 ~ncb_base[8];

  wire [7:0] rd_mux =
      ({8{hit_wp}} & wp_q)      | ({8{hit_d2}} & dram2_q) |
      ({8{hit_s3}} & shadow3_q) | ({8{hit_ec}} & ecache_q) |
      ({8{hit_nc}} & ncb_ctl_q) | ({8{hit_ns}} & ncb_st_q) |
      ({8{hit_mi}} & misc_q)    | ({8{hit_f1}} & feat1_q) |
      ({8{hit_f2}} & feat2_q)   | ({8{hit_l2}} & l2ctl_q) |
      ({8{hit_le}} & l2e_q)     | ({8{hit_lc}} & l2cd_q) |
      ({8{hit_sh}} & shen_q)    |
      ({8{hit_st}} & {3'h0, dec.snoop_inval, dec.block_write,
                      dec.l2_cacheable, dec.l1_cacheable, dec.valid});

  // ==========================================================================
  // Outputs, all registered; a single-cycle APB answer.
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      dec       <= '0;
      l2_enable <= 1'b0;
      eads_n    <= 1'b1;
    end else begin
      pready    <= psel & ~penable;
      pslverr   <= psel & ~penable & ~mapped;
      prdata    <= {24'h00_0000, rd_mux};
      l2_enable <= l2_on;
      eads_n    <= ~(cyc.start & inval & ~ncb_hit);
      dec.valid        <= cyc.start;
      dec.l1_cacheable <= cyc.start & l1_ok & ~ncb_hit;
      dec.l2_cacheable <= cyc.start & l2_ok & ~ncb_hit;
      dec.block_write  <= cyc.start & blk_w;
      dec.snoop_inval  <= cyc.start & inval & ~ncb_hit;
    end
  end

  // ==========================================================================
  // Assertions
  l1_global_a: assert property (@(posedge clock) disable iff (rst)
    (cyc.start & dram2_q[rrcc_pkg::B_GLOBAL_DIS]) |=> !dec.l1_cacheable
                                                     && !dec.l2_cacheable)
    else $error("Caching reported while globally disabled.");
  shadow_req_a: assert property (@(posedge clock) disable iff (rst)
    (cyc.start & rom & ~shadow) |=> !dec.l1_cacheable && !dec.l2_cacheable)
    else $error("Unshadowed region reported cacheable.");
  mode_reset_a: assert property (@(posedge clock)
    $fell(rst) |-> feat1_q == rrcc_pkg::RST_ZERO
                   && misc_q == rrcc_pkg::RST_ZERO)
    else $error("Mode or misc register not cleared by reset.");
  never_cd_a: assert property (@(posedge clock) disable iff (rst)
    (cyc.start & (is_d | (is_c & cyc.addr[15]))) |=> !dec.l1_cacheable)
    else $error("C8000h or D segment reported L1 cacheable.");
  new_c_a: assert property (@(posedge clock) disable iff (rst)
    (cyc.start & is_c & newmap & c_wp) |=> !dec.l1_cacheable)
    else $error("Protected C block L1 cacheable in new mode.");
  new_f_a: assert property (@(posedge clock) disable iff (rst)
    (cyc.start & is_f & newmap & ~f_rw) |=> !dec.l1_cacheable)
    else $error("Read-only F block L1 cacheable in new mode.");
  l2_read_a: assert property (@(posedge clock) disable iff (rst)
    (cyc.start & is_e & ~cyc.write & shadow & glob & l2_on & l2e_q[l2i]
     & ~ncb_hit) |=> dec.l2_cacheable)
    else $error("Enabled E block read not L2 cacheable.");
  l2_off_a: assert property (@(posedge clock) disable iff (rst)
    !l2ctl_q[rrcc_pkg::B_L2_EN] |=> !dec.l2_cacheable && !l2_enable)
    else $error("L2 used while disabled.");
  wp_block_a: assert property (@(posedge clock) disable iff (rst)
    (cyc.start & cyc.write & is_c & c_wp & shadow) |=> dec.block_write
                                                      && !dec.l2_cacheable)
    else $error("Protected write not blocked.");
  inval_a: assert property (@(posedge clock) disable iff (rst)
    dec.snoop_inval |-> !eads_n ##1 (eads_n || $past(cyc.start)))
    else $error("Snoop pulse not matched on EADS.");
  apb_ready_a: assert property (@(posedge clock) disable iff (rst)
    (psel & ~penable) |=> pready ##1 !pready)
    else $error("APB ready not a single cycle.");
endmodule // rrcc_top
`default_nettype wire

// [rrcc_cpu_model.sv]
// Processor bus model that issues cycles and captures the cacheability answer.
`timescale 1ns/1ps
`default_nettype none
module rrcc_cpu_model (
  input  wire logic                clock,
  output var  rrcc_pkg::rrcc_cyc_t cyc,
  input  wire rrcc_pkg::rrcc_dec_t dec,
  input  wire logic                eads_n
);
  initial begin
    cyc = '0;
  end

  // =========================================================================
  // One bus cycle: start pulse, then the answer one cycle later.
  // The address is inverted once the cycle is over so a stale value never
  // looks valid to the decoder.
  task automatic run(input  logic [23:0] a,
                     input  logic        w,
                     output logic [5:0]  r);
    @(posedge clock);
    cyc <= '{addr: a, write: w, start: 1'b1};
    @(posedge clock);
    cyc <= '{addr: ~a, write: ~w, start: 1'b0};
    #1;
    r = {dec, eads_n};
  endtask
endmodule // rrcc_cpu_model
`default_nettype wire

// [rrcc_top_tb_top.sv]
// Self-checking bench for the ROM region cacheability control block.
`timescale 1ns/1ps
`default_nettype none
module rrcc_top_tb_top;
  logic                clock;
  logic                rst;
  logic [11:0]         paddr;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  rrcc_pkg::rrcc_cyc_t cyc;
  rrcc_pkg::rrcc_dec_t dec;
  logic                l2_enable;
  logic                eads_n;
  logic [31:0]         rdat;
  logic                rerr;
  int                  fail_count;
  int                  total_checks;

  rrcc_top dut (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cyc(cyc), .dec(dec),
    .l2_enable(l2_enable), .eads_n(eads_n));
  rrcc_cpu_model cpu (.clock(clock), .cyc(cyc), .dec(dec), .eads_n(eads_n));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // =========================================================================
  // Report and compare helpers.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // =========================================================================
  // APB master; pready, read data and error are all taken at the rising
  // edge at which pready is sampled high, and only then is the bus released.
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        print_verdict();
      end
      @(posedge clock);
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~pwdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb({2'b00, idx, 2'b00}, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    apb({2'b00, idx, 2'b00}, 1'b0, 8'h00);
    chk(rdat, {24'h000000, e});
  endtask

  // Expected value is {l1, l2, block_write, snoop, valid, eads_n}.
  task automatic cy(input logic [23:0] a, input logic w, input logic [5:0] e);
    logic [5:0] r;
    cpu.run(a, w, r);
    chk({26'h0, r}, {26'h0, e});
  endtask

  // =========================================================================
  // Main sequence.
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    fail_count = 0;
    total_checks = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(rrcc_pkg::IDX_DRAM_CTL2, 8'hff);
    rd(rrcc_pkg::IDX_E_CACHE, 8'h0f);
    rd(rrcc_pkg::IDX_MISC_CTL, 8'h00);
    rd(rrcc_pkg::IDX_FEAT_CTL1, 8'h00);
    apb(12'h004, 1'b0, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0000_0000);
    wr(rrcc_pkg::IDX_SHADOW_EN, 8'h0f);
    wr(rrcc_pkg::IDX_DRAM_CTL2, 8'hf8);
    wr(rrcc_pkg::IDX_E_CACHE, 8'h00);
    wr(rrcc_pkg::IDX_L2_CD_EN, 8'hff);
    wr(rrcc_pkg::IDX_L2_E_EN, 8'h0f);
    wr(rrcc_pkg::IDX_L2_CTL, 8'h20);
    wr(rrcc_pkg::IDX_SHADOW_CTL3, 8'h20);
    wr(rrcc_pkg::IDX_SHADOW_WP, 8'h08);
    // Compatible mode: protection does not gate the first level here.
    cy(24'h0c0000, 1'b0, 6'b110011);
    cy(24'h0c8000, 1'b0, 6'b010011);
    cy(24'h0d0000, 1'b0, 6'b010011);
    cy(24'h0e0000, 1'b0, 6'b110011);
    cy(24'h0f0000, 1'b0, 6'b110011);
    cy(24'h0c0000, 1'b1, 6'b101011);
    cy(24'h0d4000, 1'b1, 6'b010011);
    cy(24'h0e0000, 1'b1, 6'b101011);
    cy(24'h0f0000, 1'b1, 6'b101011);
    wr(rrcc_pkg::IDX_FEAT_CTL1, 8'h01);
    cy(24'h0c0000, 1'b0, 6'b010011);
    cy(24'h0e0000, 1'b0, 6'b010011);
    cy(24'h0f0000, 1'b0, 6'b010011);
    cy(24'h0c0000, 1'b1, 6'b001011);
    wr(rrcc_pkg::IDX_SHADOW_CTL3, 8'h00);
    wr(rrcc_pkg::IDX_SHADOW_WP, 8'h00);
    wr(rrcc_pkg::IDX_FEAT_CTL2, 8'h02);
    cy(24'h0c0000, 1'b0, 6'b110011);
    cy(24'h0ec000, 1'b1, 6'b110011);
    cy(24'h0e0000, 1'b1, 6'b110011);
    cy(24'h0f0000, 1'b0, 6'b110011);
    wr(rrcc_pkg::IDX_MISC_CTL, 8'h04);
    rd(rrcc_pkg::IDX_MISC_CTL, 8'h04);
    cy(24'h0f0000, 1'b1, 6'b110110);
    wr(rrcc_pkg::IDX_NCB2_CTL, 8'h40);
    wr(rrcc_pkg::IDX_NCB2_START, 8'h0c);
    cy(24'h0f0000, 1'b0, 6'b000011);
    wr(rrcc_pkg::IDX_NCB2_CTL, 8'h80);
    wr(rrcc_pkg::IDX_DRAM_CTL2, 8'hfa);
    cy(24'h0f0000, 1'b0, 6'b000011);
    wr(rrcc_pkg::IDX_DRAM_CTL2, 8'hf8);
    wr(rrcc_pkg::IDX_SHADOW_EN, 8'h00);
    cy(24'h0f0000, 1'b0, 6'b000011);
    chk({31'h0, l2_enable}, 32'h1);
    wr(rrcc_pkg::IDX_L2_CTL, 8'h00);
    repeat (2) @(posedge clock);
    chk({31'h0, l2_enable}, 32'h0);
    print_verdict();
  end
endmodule // rrcc_top_tb_top
`default_nettype wire
